// >>> shared/elc_pkg.sv
// shared constants and types of the edge line controller
package elc_pkg;

  // line count and bus widths
  localparam int unsigned LINE_CNT = 24;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIN_LINES = 16;
  localparam int unsigned INT_LINES = 8;
  localparam int unsigned SYNC_W   = 2 * LINE_CNT;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_LINE_INTERRUPT_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LINE_EVENT_MASK     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RISING_EDGE_SELECT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FALLING_EDGE_SELECT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SOFTWARE_TRIGGER    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PENDING_STATUS      = 8'h14;

  // field layout: lines in the low bits, reserved bits above read zero
  localparam int unsigned LINE_LSB = 0;
  localparam int unsigned LINE_MSB = 23;
  localparam int unsigned RSV_W    = DATA_W - LINE_CNT;
  localparam int unsigned TOP_LINE = 23;

  // reset values
  localparam logic [LINE_CNT-1:0] RST_LINES = 24'h000000;
  localparam logic [DATA_W-1:0]   RST_WORD  = 32'h00000000;
  localparam logic [RSV_W-1:0]    RSV_ZERO  = 8'h00;

  // line availability with and without the topmost line
  localparam logic [LINE_CNT-1:0] LINES_FULL  = 24'hffffff;
  localparam logic [LINE_CNT-1:0] LINES_SMALL = 24'h7fffff;

  // pin edge to pending bit, in clock edges (two sync stages plus compare)
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned EDGE_TO_PEND = SYNC_STAGES + 1;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } elc_bus_req_t;

  // internal wake sources feeding lines 16 to 23
  typedef struct packed {
    logic chan_acq;    // line 23
    logic comp2_wake;  // line 22
    logic comp1_wake;  // line 21
    logic cal_wake;    // line 20
    logic tamper_ts;   // line 19
    logic usb_wake;    // line 18
    logic cal_alarm;   // line 17
    logic volt_det;    // line 16
  } elc_int_src_t;

endpackage : elc_pkg

// >>> verilog/elc_sync.sv
// two-stage level synchroniser bank into the bus clock
`timescale 1ns/1ps

module elc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,   // bus clock
  input  wire logic             rstn_i,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_i, // levels from another domain
  output logic      [WIDTH-1:0] sync_o   // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : elc_sync

// >>> verilog/elc_edge_catch.sv
// per-line asynchronous edge catcher built from two toggle flops
`timescale 1ns/1ps

module elc_edge_catch (
  input  wire logic line_i,      // raw line level, any timing
  input  wire logic rstn_i,      // async reset, active low
  output logic      rise_tgl_o,  // flips on every rising edge
  output logic      fall_tgl_o   // flips on every falling edge
);

  logic rise_q;
  logic fall_q;

  // the line itself clocks the toggles, so pulses narrower than a bus
  // clock period still leave a trace; the bus side compares levels
  always_ff @(posedge line_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= ~rise_q;
    end
  end

  always_ff @(negedge line_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= ~fall_q;
    end
  end

  assign rise_tgl_o = rise_q;
  assign fall_tgl_o = fall_q;

endmodule : elc_edge_catch

// >>> verilog/elc_top.sv
// edge line controller: edge detection, masks, pending bits, register port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module elc_top
  import elc_pkg::*;
#(
  parameter bit HAS_TOP_LINE = 1'b1
) (
  input  wire logic                clk_i,       // bus clock, 200 MHz
  input  wire logic                rstn_i,      // async reset, active low
  input  wire elc_bus_req_t        bus_i,       // register request
  output logic      [DATA_W-1:0]   rdata_o,     // read data, cycle after read
  input  wire logic [PIN_LINES-1:0] pin_line_i, // lines 0..15 from pin mux
  input  wire elc_int_src_t        int_src_i,   // lines 16..23 wake sources
  output logic      [LINE_CNT-1:0] irq_o,       // per-line interrupt request
  output logic      [LINE_CNT-1:0] evt_o,       // per-line event pulse
  output logic                     wake_evt_o   // any event, one-cycle pulse
);

  // lines that exist in this build
  localparam logic [LINE_CNT-1:0] LINE_AVAIL = HAS_TOP_LINE ? LINES_FULL
                                                            : LINES_SMALL;

  // register address match, used by every register decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // software state
  logic [LINE_CNT-1:0] imask_q;
  logic [LINE_CNT-1:0] emask_q;
  logic [LINE_CNT-1:0] rsel_q;
  logic [LINE_CNT-1:0] fsel_q;
  logic [LINE_CNT-1:0] swtrg_q;
  logic [LINE_CNT-1:0] pend_q;
  logic [LINE_CNT-1:0] pend_d;
  logic [LINE_CNT-1:0] swtrg_d;

  // edge path
  logic [LINE_CNT-1:0] line_raw;
  logic [LINE_CNT-1:0] rise_tgl;
  logic [LINE_CNT-1:0] fall_tgl;
  logic [SYNC_W-1:0]   tgl_sync;
  logic [LINE_CNT-1:0] rise_prev_q;
  logic [LINE_CNT-1:0] fall_prev_q;

  // outputs
  logic [LINE_CNT-1:0] irq_q;
  logic [LINE_CNT-1:0] evt_q;
  logic                wake_q;
  logic [DATA_W-1:0]   rdata_q;

  // line assembly: pins low, fixed internal sources above
  assign line_raw = {int_src_i.chan_acq, int_src_i.comp2_wake,
                     int_src_i.comp1_wake, int_src_i.cal_wake,
                     int_src_i.tamper_ts, int_src_i.usb_wake,
                     int_src_i.cal_alarm, int_src_i.volt_det,
                     pin_line_i};

  // one asynchronous edge catcher per line
  genvar gi;
  generate
    for (gi = 0; gi < LINE_CNT; gi++) begin : g_line
      elc_edge_catch u_catch (
        .line_i     (line_raw[gi]),
        .rstn_i     (rstn_i),
        .rise_tgl_o (rise_tgl[gi]),
        .fall_tgl_o (fall_tgl[gi])
      );
    end
  endgenerate

  // toggles cross into the bus clock as levels
  elc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i ({fall_tgl, rise_tgl}),
    .sync_o  (tgl_sync)
  );

  logic [LINE_CNT-1:0] rise_sync;
  logic [LINE_CNT-1:0] fall_sync;
  assign rise_sync = tgl_sync[LINE_CNT-1:0];
  assign fall_sync = tgl_sync[SYNC_W-1:LINE_CNT];

  // last seen toggle levels, compared to find new edges
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_prev_q <= RST_LINES;
      fall_prev_q <= RST_LINES;
    end else begin
      rise_prev_q <= rise_sync;
      fall_prev_q <= fall_sync;
    end
  end

  // bus decode
  logic wr_imask;
  logic wr_emask;
  logic wr_rsel;
  logic wr_fsel;
  logic wr_swtrg;
  logic wr_pend;
  logic [LINE_CNT-1:0] wr_lines;
  assign wr_imask = bus_i.we & addr_hit(bus_i.addr, OFF_LINE_INTERRUPT_MASK);
  assign wr_emask = bus_i.we & addr_hit(bus_i.addr, OFF_LINE_EVENT_MASK);
  assign wr_rsel  = bus_i.we & addr_hit(bus_i.addr, OFF_RISING_EDGE_SELECT);
  assign wr_fsel  = bus_i.we & addr_hit(bus_i.addr, OFF_FALLING_EDGE_SELECT);
  assign wr_swtrg = bus_i.we & addr_hit(bus_i.addr, OFF_SOFTWARE_TRIGGER);
  assign wr_pend  = bus_i.we & addr_hit(bus_i.addr, OFF_PENDING_STATUS);
  // bits above the lines are dropped; software keeps them zero anyway
  assign wr_lines = bus_i.wdata[LINE_MSB:LINE_LSB] & LINE_AVAIL;

  // edge hits and trigger selection
  logic [LINE_CNT-1:0] rise_hit;
  logic [LINE_CNT-1:0] fall_hit;
  logic [LINE_CNT-1:0] hw_trig;
  logic [LINE_CNT-1:0] sw_set;
  logic [LINE_CNT-1:0] any_trig;
  logic [LINE_CNT-1:0] pend_clr;
  logic [LINE_CNT-1:0] pend_set;
  logic [LINE_CNT-1:0] evt_d;
  assign rise_hit = rise_sync ^ rise_prev_q;
  assign fall_hit = fall_sync ^ fall_prev_q;
  // an edge that meets a write of its own select register is dropped,
  // since the select value is changing under it
  assign hw_trig  = ((rise_hit & rsel_q & {LINE_CNT{~wr_rsel}}) |
                     (fall_hit & fsel_q & {LINE_CNT{~wr_fsel}}))
                    & LINE_AVAIL;
  // software request only on a 0 to 1 change of its bit
  assign sw_set   = {LINE_CNT{wr_swtrg}} & wr_lines & ~swtrg_q;
  assign any_trig = hw_trig | sw_set;
  assign pend_clr = {LINE_CNT{wr_pend}} & wr_lines;
  // pending follows the interrupt path only; events leave it alone
  assign pend_set = any_trig & imask_q;
  // set beats clear, so an edge in the clearing cycle is kept
  assign pend_d   = (pend_q & ~pend_clr) | pend_set;
  assign swtrg_d  = (swtrg_q & ~pend_clr) | sw_set;
  assign evt_d    = any_trig & emask_q;

  // mask and select registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      imask_q <= RST_LINES;
      emask_q <= RST_LINES;
    end else begin
      if (wr_imask) imask_q <= wr_lines;
      if (wr_emask) emask_q <= wr_lines;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsel_q <= RST_LINES;
      fsel_q <= RST_LINES;
    end else begin
      if (wr_rsel) rsel_q <= wr_lines;
      if (wr_fsel) fsel_q <= wr_lines;
    end
  end

  // pending and software trigger state; pending resets to zero here
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q  <= RST_LINES;
      swtrg_q <= RST_LINES;
    end else begin
      pend_q  <= pend_d;
      swtrg_q <= swtrg_d;
    end
  end

  // outputs all leave from flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q  <= RST_LINES;
      evt_q  <= RST_LINES;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= pend_q & imask_q;
      evt_q  <= evt_d;
      wake_q <= |evt_d;
    end
  end

  // read mux; unmapped addresses read zero, reserved bits read zero
  logic [LINE_CNT-1:0] rd_lines;
  logic [DATA_W-1:0]   rdata_d;
  assign rd_lines =
    addr_hit(bus_i.addr, OFF_LINE_INTERRUPT_MASK) ? imask_q :
    addr_hit(bus_i.addr, OFF_LINE_EVENT_MASK)     ? emask_q :
    addr_hit(bus_i.addr, OFF_RISING_EDGE_SELECT)  ? rsel_q  :
    addr_hit(bus_i.addr, OFF_FALLING_EDGE_SELECT) ? fsel_q  :
    addr_hit(bus_i.addr, OFF_SOFTWARE_TRIGGER)    ? swtrg_q :
    addr_hit(bus_i.addr, OFF_PENDING_STATUS)      ? pend_q  : RST_LINES;
  // only whole words exist on this port, so no lane logic is needed
  assign rdata_d = bus_i.re ? {RSV_ZERO, rd_lines} : RST_WORD;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o    = rdata_q;
  assign irq_o      = irq_q;
  assign evt_o      = evt_q;
  assign wake_evt_o = wake_q;

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // software writes a trigger bit that was zero, with interrupt unmasked
  sequence s_sw_write;
    wr_swtrg && |(wr_lines & ~swtrg_q & imask_q);
  endsequence

  sequence s_pend_follows;
    ##1 ((pend_q & $past(wr_lines & ~swtrg_q & imask_q))
         == $past(wr_lines & ~swtrg_q & imask_q));
  endsequence

  sequence s_irq_follows;
    ##2 ((irq_o & $past(wr_lines & ~swtrg_q & imask_q, 2))
         == $past(wr_lines & ~swtrg_q & imask_q, 2));
  endsequence

  AST_SW_SETS_PEND: assert property (
    s_sw_write |-> s_pend_follows)
    else $error("software trigger did not set pending");

  AST_SW_RAISES_IRQ: assert property (
    (s_sw_write ##0 !wr_pend ##1 !wr_pend && !wr_imask) |->
      ##1 (|(irq_o & $past(pend_q)))) 
    else $error("software trigger did not raise interrupt");

  AST_PEND_ONLY_CLEARED_BY_WRITE: assert property (
    ((~pend_q & $past(pend_q)) & ~$past(pend_clr)) == RST_LINES)
    else $error("pending bit fell without a clearing write");

  AST_PEND_SET_NEEDS_IMASK: assert property (
    ((pend_q & ~$past(pend_q)) & ~$past(imask_q)) == RST_LINES)
    else $error("pending set on a line with interrupt masked");

  AST_IRQ_TRACKS_PEND: assert property (
    (pend_q == $past(pend_q) && imask_q == $past(imask_q)) |=>
      irq_o == $past(pend_q & imask_q))
    else $error("interrupt output differs from pending and mask");

  AST_EVT_NEEDS_EMASK: assert property (
    (evt_o & ~$past(emask_q)) == RST_LINES)
    else $error("event pulse on a masked line");

  AST_WAKE_IS_ANY_EVT: assert property (
    wake_evt_o == (|evt_o))
    else $error("wake pulse disagrees with line events");

  AST_RISE_WRITE_BLOCKS: assert property (
    (wr_rsel && !wr_swtrg && ((rise_hit & ~(fall_hit & fsel_q)) == rise_hit))
      |=> ((pend_q & ~$past(pend_q) & $past(rise_hit)) == RST_LINES))
    else $error("pending set by a rising edge during select write");

  AST_READ_ONE_CYCLE: assert property (
    (bus_i.re && addr_hit(bus_i.addr, OFF_LINE_INTERRUPT_MASK)) |=>
      rdata_o == {RSV_ZERO, $past(imask_q)} ##1 (rdata_o == RST_WORD || $past(bus_i.re)))
    else $error("mask read data wrong or held too long");

  AST_RSV_ZERO: assert property (
    rdata_o[DATA_W-1:LINE_CNT] == RSV_ZERO)
    else $error("reserved read bits not zero");

  AST_TOP_LINE_ABSENT: assert property (
    !HAS_TOP_LINE |-> (pend_q[TOP_LINE] == 1'b0 && imask_q[TOP_LINE] == 1'b0))
    else $error("absent top line shows state");

  AST_SWTRG_CLEARS_WITH_PEND: assert property (
    (wr_pend && |(wr_lines & swtrg_q) && !wr_swtrg) |=>
      ((swtrg_q & $past(wr_lines)) == RST_LINES))
    else $error("software trigger bit not cleared with pending");

  // a hardware trigger on an unmasked line reaches pending and events one edge later
  sequence s_hw_int;
    |(hw_trig & imask_q);
  endsequence

  sequence s_hw_evt;
    |(hw_trig & emask_q);
  endsequence

  AST_HW_SETS_PEND: assert property (
    s_hw_int |=>
      ((pend_q & $past(hw_trig & imask_q)) == $past(hw_trig & imask_q)))
    else $error("selected edge did not set pending");

  AST_HW_RAISES_EVT: assert property (
    s_hw_evt |=>
      ((evt_o & $past(hw_trig & emask_q)) == $past(hw_trig & emask_q)))
    else $error("selected edge on an event line gave no pulse");

  // with both selects on, no edge of either polarity is lost outside select writes
  AST_BOTH_EDGES: assert property (
    (!wr_rsel && !wr_fsel) |->
      (((rise_hit | fall_hit) & rsel_q & fsel_q & LINE_AVAIL & ~hw_trig) == RST_LINES))
    else $error("edge lost on a line with both selects on");

  AST_IMASK_WRITE: assert property (
    wr_imask |=> (imask_q == $past(wr_lines)))
    else $error("interrupt mask write did not land");

  AST_RSEL_WRITE: assert property (
    wr_rsel |=> (rsel_q == $past(wr_lines)))
    else $error("rising select write did not land");

  AST_FSEL_WRITE: assert property (
    wr_fsel |=> (fsel_q == $past(wr_lines)))
    else $error("falling select write did not land");

endmodule : elc_top

// >>> verif/elc_line_src.sv
// far-side model: pin mux outputs and internal wake sources on the lines
`timescale 1ns/1ps

module elc_line_src
  import elc_pkg::*;
(
  output logic [PIN_LINES-1:0] pin_o, // lines 0..15 after the pin mux
  output elc_int_src_t         src_o  // lines 16..23 wake sources
);
  logic [LINE_CNT-1:0] lvl = RST_LINES;

  // low lines come from pins, high lines from wake sources
  assign pin_o = lvl[PIN_LINES-1:0];
  assign src_o = lvl[LINE_CNT-1:PIN_LINES];

  // steady level on one line
  task automatic set_line(input int idx, input logic val);
    lvl[idx] = val;
  endtask : set_line

  // 1 ns glitch, far below the bus clock period
  task automatic glitch(input int idx);
    lvl[idx] = ~lvl[idx];
    #1;
    lvl[idx] = ~lvl[idx];
  endtask : glitch
endmodule : elc_line_src

// >>> verif/elc_top_test.sv
// self-checking bench for the edge line controller
`timescale 1ns/1ps

module elc_top_test
  import elc_pkg::*;
;
  logic                 clk_i;
  logic                 rstn_i;
  elc_bus_req_t         bus;
  logic [DATA_W-1:0]    rdata;
  logic [DATA_W-1:0]    d;
  logic [PIN_LINES-1:0] pins;
  elc_int_src_t         srcs;
  logic [LINE_CNT-1:0]  irq;
  logic [LINE_CNT-1:0]  evt;
  logic                 wake;
  logic [LINE_CNT-1:0]  ev_or;
  int                   ev_n;
  int                   mismatches;
  int                   checked;
  int                   cyc;
  integer               seed;
  integer               r;

  elc_top #(.HAS_TOP_LINE(1'b1)) elc_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
    .pin_line_i(pins), .int_src_i(srcs), .irq_o(irq), .evt_o(evt),
    .wake_evt_o(wake));
  elc_line_src elc_line_src_i (.pin_o(pins), .src_o(srcs));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // event tally; the cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (wake === 1'b1) ev_n++;
    ev_or |= evt;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one whole-word write per call, strobe high for one cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rchk

  // triggers expected: 0 rise, 1 fall, 2 glitch (merges to one), 3 rise then fall
  function automatic int ntrig(input int kind, input bit rs, input bit fs);
    case (kind)
      0: return rs;
      1: return fs;
      2: return rs | fs;
      default: return rs + fs;
    endcase
  endfunction : ntrig

  function automatic logic [DATA_W-1:0] ex(input logic [LINE_CNT-1:0] b, input bit on);
    return on ? {RSV_ZERO, b} : RST_WORD;
  endfunction : ex

  task automatic trial(input int ln, input int kind, input bit im, input bit em,
                       input bit rs, input bit fs);
    logic [LINE_CNT-1:0] b;
    int                  n;
    b = 24'h000001 << ln;
    n = ntrig(kind, rs, fs);
    // park the line with both selects off so the setup makes no trigger
    wr(OFF_RISING_EDGE_SELECT, RST_WORD);
    wr(OFF_FALLING_EDGE_SELECT, RST_WORD);
    elc_line_src_i.set_line(ln, kind == 1);
    repeat (5) @(posedge clk_i);
    wr(OFF_LINE_INTERRUPT_MASK, ex(b, im));
    wr(OFF_LINE_EVENT_MASK, ex(b, em));
    wr(OFF_RISING_EDGE_SELECT, ex(b, rs));
    wr(OFF_FALLING_EDGE_SELECT, ex(b, fs));
    wr(OFF_PENDING_STATUS, {RSV_ZERO, LINES_FULL});
    @(posedge clk_i);
    #1;
    ev_n = 0;
    ev_or = '0;
    if (kind == 2) elc_line_src_i.glitch(ln);
    else elc_line_src_i.set_line(ln, kind != 1);
    if (kind == 3) begin
      repeat (10) @(posedge clk_i);
      #2 elc_line_src_i.set_line(ln, 1'b0);
    end
    repeat (8) @(posedge clk_i);
    #1;
    chk(ev_n, em ? n : 0);
    chk(ev_or, ex(b, em && n > 0));
    chk(irq, ex(b, im && n > 0));
    rchk(OFF_PENDING_STATUS, ex(b, im && n > 0));
    wr(OFF_PENDING_STATUS, RST_WORD);
    rchk(OFF_PENDING_STATUS, ex(b, im && n > 0));
    wr(OFF_PENDING_STATUS, {RSV_ZERO, b});
    repeat (3) @(posedge clk_i);
    #1 chk(irq, RST_WORD);
    rchk(OFF_PENDING_STATUS, RST_WORD);
  endtask : trial

  task automatic swt(input int ln, input bit im, input bit em);
    logic [LINE_CNT-1:0] b;
    b = 24'h000001 << ln;
    wr(OFF_LINE_INTERRUPT_MASK, ex(b, im));
    wr(OFF_LINE_EVENT_MASK, ex(b, em));
    @(posedge clk_i);
    #1;
    ev_n = 0;
    wr(OFF_SOFTWARE_TRIGGER, {RSV_ZERO, b});
    wr(OFF_SOFTWARE_TRIGGER, {RSV_ZERO, b});
    repeat (2) @(posedge clk_i);
    #1 chk(irq, ex(b, im));
    chk(ev_n, em ? 1 : 0);
    rchk(OFF_SOFTWARE_TRIGGER, {RSV_ZERO, b});
    rchk(OFF_PENDING_STATUS, ex(b, im));
    wr(OFF_PENDING_STATUS, {RSV_ZERO, b});
    rchk(OFF_SOFTWARE_TRIGGER, RST_WORD);
  endtask : swt

  initial begin
    seed = 32'h8f0d8838;
    rstn_i = 1'b0;
    bus = '0;
    ev_or = '0;
    ev_n = 0;
    mismatches = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    // every register, and the unmapped word after them, reads zero from reset
    for (int a = 0; a <= 24; a += 4) begin
      rchk(ADDR_W'(a), RST_WORD);
    end
    // random words within the line bits; software keeps bits 31:24 at zero
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        d = $random(seed) & 32'h00ffffff;
        wr(ADDR_W'(k * 4), d);
        rchk(ADDR_W'(k * 4), d & 32'h00ffffff);
      end
      wr(8'h18, $random(seed));
      rchk(8'h18, RST_WORD);
    end
    // every edge kind against every select pair, corner lines first
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      trial((k == 0) ? 0 : (k == 1) ? 23 : (k == 2) ? 15 : (k == 3) ? 16
            : $unsigned(r) % LINE_CNT, k / 4, r[8] | (k % 3 == 0),
            r[9] | (k % 3 == 1), k[0], k[1]);
    end
    // a rising edge seen in the very cycle that rewrites its select sets nothing
    wr(OFF_LINE_INTERRUPT_MASK, {RSV_ZERO, LINES_FULL});
    wr(OFF_FALLING_EDGE_SELECT, RST_WORD);
    wr(OFF_RISING_EDGE_SELECT, 32'h00000004);
    #1 elc_line_src_i.set_line(2, 1'b0);
    repeat (5) @(posedge clk_i);
    wr(OFF_PENDING_STATUS, {RSV_ZERO, LINES_FULL});
    @(posedge clk_i);
    #1 elc_line_src_i.set_line(2, 1'b1);
    // two edges later the edge meets the select write in the bus domain
    @(posedge clk_i);
    wr(OFF_RISING_EDGE_SELECT, 32'h00000004);
    repeat (4) @(posedge clk_i);
    rchk(OFF_PENDING_STATUS, RST_WORD);
    for (int k = 0; k < 4; k++) begin
      swt($unsigned($random(seed)) % LINE_CNT, k[0], k[1]);
    end
    print_verdict();
  end
endmodule : elc_top_test
